// file: pkg/ptc_pkg.sv
package ptc_pkg;

    // Register byte offsets
    localparam logic [11:0] PTC_TX_SEC_OFS   = 12'h1e0;
    localparam logic [11:0] PTC_RX_SEC_OFS   = 12'h1e8;
    localparam logic [11:0] PTC_CTRL_OFS     = 12'h1f0;
    localparam logic [11:0] PTC_STAT_OFS     = 12'h1f4;
    localparam logic [11:0] PTC_PEER_NS_OFS  = 12'h1fc;

    // Reset values
    localparam logic [31:0] PTC_CAPT_RST     = 32'h0000_0000;
    localparam logic [2:0]  PTC_CTRL_RST     = 3'h7;
    localparam logic [2:0]  PTC_STAT_RST     = 3'h0;

    // Widths of the timer fields
    localparam int          PTC_SEC_W        = 32;
    localparam int          PTC_NS_W         = 30;

    // Channel index, also bit position in control and status
    localparam int          PTC_CH_TX        = 0;
    localparam int          PTC_CH_RX        = 1;
    localparam int          PTC_CH_PEER      = 2;
    localparam int          PTC_NUM_CH       = 3;

endpackage : ptc_pkg

// file: src/ptc_capture_reg.sv
`timescale 1ns/1ps

// One read-only capture register with its update pulse
module ptc_capture_reg
    import ptc_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        load_i,
    input  wire logic [31:0] data_i,
    output logic      [31:0] value_o,
    output logic             updated_o
);

    // Latch the timer value on the capture edge
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_o <= PTC_CAPT_RST;
        end else if (load_i) begin
            value_o <= data_i;
        end
    end

    // One-cycle pulse for every update, so back-to-back captures all show
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            updated_o <= 1'b0;
        end else begin
            updated_o <= load_i;
        end
    end

endmodule : ptc_capture_reg

// file: src/ptc_event_capture.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps

module ptc_event_capture
    import ptc_pkg::*;
(
    input  wire logic                 clock_i,
    input  wire logic                 rst_n_i,
    // APB slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // Timer unit
    input  wire logic [PTC_SEC_W-1:0] tmr_sec_i,
    input  wire logic [PTC_NS_W-1:0]  tmr_nsec_i,
    // MII side frame markers
    input  wire logic                 tx_sfd_i,
    input  wire logic                 tx_ptp_event_i,
    input  wire logic                 rx_sfd_i,
    input  wire logic                 rx_ptp_event_i,
    input  wire logic                 rx_peer_event_i,
    // Interrupt conditions, one pulse per update
    output logic      [2:0]           capture_irq_o
);

    logic [2:0]  load;
    logic [31:0] cap_data [PTC_NUM_CH];
    logic [31:0] cap_value [PTC_NUM_CH];
    logic [2:0]  cap_updated;
    logic [2:0]  ctrl_en_r;
    logic [2:0]  stat_new_r;
    logic [2:0]  stat_clr;
    logic        setup_ph;
    logic        wr_take;
    logic        rd_take;
    logic [31:0] rd_mux;
    logic        addr_ok;

    // Capture triggers; a disabled channel keeps its last value
    always_comb begin
        load[PTC_CH_TX]   = tx_sfd_i & tx_ptp_event_i
                            & ctrl_en_r[PTC_CH_TX];
        load[PTC_CH_RX]   = rx_sfd_i & rx_ptp_event_i
                            & ctrl_en_r[PTC_CH_RX];
        load[PTC_CH_PEER] = rx_sfd_i & rx_peer_event_i
                            & ctrl_en_r[PTC_CH_PEER];
    end

    // Values to latch; nanoseconds sit in the low 30 bits
    always_comb begin
        cap_data[PTC_CH_TX]   = tmr_sec_i;
        cap_data[PTC_CH_RX]   = tmr_sec_i;
        cap_data[PTC_CH_PEER] = {2'h0, tmr_nsec_i};
    end

    // One capture register per channel
    for (genvar g = 0; g < PTC_NUM_CH; g++) begin : g_ch
        ptc_capture_reg u_cap (
            .clock_i   (clock_i),
            .rst_n_i   (rst_n_i),
            .load_i    (load[g]),
            .data_i    (cap_data[g]),
            .value_o   (cap_value[g]),
            .updated_o (cap_updated[g])
        );
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            capture_irq_o <= 3'h0;
        end else begin
            capture_irq_o <= load;
        end
    end

    // APB phase decode
    assign setup_ph = psel_i & ~penable_i;
    assign wr_take  = psel_i & penable_i & pready_o & pwrite_i;
    assign rd_take  = psel_i & penable_i & pready_o & ~pwrite_i;

    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (paddr_i)
            PTC_TX_SEC_OFS:  rd_mux = cap_value[PTC_CH_TX];
            PTC_RX_SEC_OFS:  rd_mux = cap_value[PTC_CH_RX];
            PTC_PEER_NS_OFS: rd_mux = cap_value[PTC_CH_PEER];
            PTC_CTRL_OFS:    rd_mux = {29'h0, ctrl_en_r};
            PTC_STAT_OFS:    rd_mux = {29'h0, stat_new_r};
            default:         addr_ok = 1'b0;
        endcase
    end

    // Ready one cycle after setup: every transfer has one wait-free access
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready_o  <= 1'b1;
            pslverr_o <= ~addr_ok;
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
    end

    // Channel enables; only the control word is writable
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_en_r <= PTC_CTRL_RST;
        end else if (wr_take && paddr_i == PTC_CTRL_OFS) begin
            ctrl_en_r <= pwdata_i[2:0];
        end
    end

    // Reading a capture word acknowledges its new-value flag
    always_comb begin
        stat_clr = 3'h0;
        if (rd_take) begin
            stat_clr[PTC_CH_TX]   = paddr_i == PTC_TX_SEC_OFS;
            stat_clr[PTC_CH_RX]   = paddr_i == PTC_RX_SEC_OFS;
            stat_clr[PTC_CH_PEER] = paddr_i == PTC_PEER_NS_OFS;
        end
    end

    // New-value flags; a capture in the clearing cycle wins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_new_r <= PTC_STAT_RST;
        end else begin
            stat_new_r <= (stat_new_r & ~stat_clr) | load;
        end
    end

    // Checks next to the capture path
    tx_capture_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (tx_sfd_i && tx_ptp_event_i && ctrl_en_r[PTC_CH_TX])
        |=> (cap_value[PTC_CH_TX] == $past(tmr_sec_i)))
        else $error("tx seconds not captured");

    rx_capture_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (rx_sfd_i && rx_ptp_event_i && ctrl_en_r[PTC_CH_RX])
        |=> (cap_value[PTC_CH_RX] == $past(tmr_sec_i)))
        else $error("rx seconds not captured");

    peer_capture_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (rx_sfd_i && rx_peer_event_i && ctrl_en_r[PTC_CH_PEER])
        |=> (cap_value[PTC_CH_PEER] == {2'h0, $past(tmr_nsec_i)}))
        else $error("peer nanoseconds not captured");

    capture_irq_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !$stable(cap_value[PTC_CH_RX]) |-> capture_irq_o[PTC_CH_RX])
        else $error("rx update without interrupt");

    irq_match_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        capture_irq_o == cap_updated)
        else $error("interrupt and update pulse differ");

    hold_value_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !load[PTC_CH_TX] |=> $stable(cap_value[PTC_CH_TX]))
        else $error("tx capture changed without event");

    // Hold checks: a stray load would corrupt a stored timestamp
    rx_hold_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !load[PTC_CH_RX] |=> $stable(cap_value[PTC_CH_RX]))
        else $error("rx capture changed without event");

    peer_hold_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !load[PTC_CH_PEER] |=> $stable(cap_value[PTC_CH_PEER]))
        else $error("peer capture changed without event");

    // Interrupt checks for the other two channels
    tx_irq_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !$stable(cap_value[PTC_CH_TX]) |-> capture_irq_o[PTC_CH_TX])
        else $error("tx update without interrupt");

    peer_irq_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !$stable(cap_value[PTC_CH_PEER]) |-> capture_irq_o[PTC_CH_PEER])
        else $error("peer update without interrupt");

    // A pulse leaves its flag set, even under a clearing read
    status_set_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (capture_irq_o & ~stat_new_r) == 3'h0)
        else $error("interrupt without status flag");

    // A disabled peer channel must stay silent however busy the wire is
    gated_irq_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !ctrl_en_r[PTC_CH_PEER] |=> !capture_irq_o[PTC_CH_PEER])
        else $error("peer interrupt while disabled");

endmodule : ptc_event_capture

// file: tb/ptc_phy_model.sv
`timescale 1ns/1ps

// Frame-start markers as the PHY side presents them
module ptc_phy_model (
    input  wire logic clock_i,
    output logic      tx_sfd_o,
    output logic      tx_evt_o,
    output logic      rx_sfd_o,
    output logic      rx_evt_o,
    output logic      peer_evt_o
);
    // Idle: no SFD, qualifiers high to catch ungated captures
    initial begin
        {tx_sfd_o, rx_sfd_o} = 2'h0;
        {peer_evt_o, rx_evt_o, tx_evt_o} = 3'h7;
    end
    // SFD for n back-to-back cycles, then qualifiers flipped
    task automatic sfd(input logic [2:0] m, input int n);
        {peer_evt_o, rx_evt_o, tx_evt_o} <= m;
        {rx_sfd_o, tx_sfd_o} <= {|m[2:1], m[0]};
        repeat (n) @(posedge clock_i);
        {peer_evt_o, rx_evt_o, tx_evt_o} <= ~m;
        {rx_sfd_o, tx_sfd_o} <= 2'h0;
    endtask : sfd
endmodule : ptc_phy_model

// file: tb/tb_top.sv
`timescale 1ns/1ps

module tb_top
    import ptc_pkg::*;
;
    logic        clk, rst_n, psel, penable, pwrite, pready, perr, e;
    logic        txs, txe, rxs, rxe, pre;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, sec;
    logic [29:0] ns;
    logic [2:0]  irq, en;
    logic [7:0]  irq_n [3];
    logic [7:0]  exp_n [3];
    logic [31:0] exp_v [3];
    logic [11:0] ofs [3] = '{PTC_TX_SEC_OFS, PTC_RX_SEC_OFS, PTC_PEER_NS_OFS};
    int          bad_count, cmp_count;

    ptc_phy_model phy (.clock_i(clk), .tx_sfd_o(txs), .tx_evt_o(txe),
        .rx_sfd_o(rxs), .rx_evt_o(rxe), .peer_evt_o(pre));
    ptc_event_capture uut (.clock_i(clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(perr), .tmr_sec_i(sec), .tmr_nsec_i(ns),
        .tx_sfd_i(txs), .tx_ptp_event_i(txe), .rx_sfd_i(rxs),
        .rx_ptp_event_i(rxe), .rx_peer_event_i(pre), .capture_irq_o(irq));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Running timer; pulses counted so none can hide
    always @(posedge clk) begin
        sec <= sec + 32'h1;
        ns  <= ns + 30'h3;
        foreach (irq_n[i]) irq_n[i] <= irq_n[i] + 8'(irq[i] === 1'b1);
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            bad_count++;
            $display("FAIL %0t got %h want %h", $time, g, x);
        end
    endtask : chk

    // Setup edge, then hold access until ready is seen
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Ready, data and error are taken at the same rising edge
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        {rd, e} = {prdata, perr};
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] x,
                       input logic xe);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask : rdc

    task automatic t_reset();
        foreach (ofs[i]) rdc(ofs[i], PTC_CAPT_RST, 1'b0);
        rdc(PTC_CTRL_OFS, {29'h0, PTC_CTRL_RST}, 1'b0);
        // Capture word must shrug off a write
        apb(1'b1, PTC_RX_SEC_OFS, 32'hffff_ffff);
        rdc(PTC_RX_SEC_OFS, 32'h0, 1'b0);
        rdc(12'h100, 32'h0, 1'b1);
    endtask : t_reset

    // Expected value is the timer at the last capture edge
    task automatic t_cap(input logic [2:0] m, input int n);
        @(negedge clk);
        foreach (ofs[i]) if (m[i] && en[i]) begin
            exp_v[i] = (i == 2) ? {2'h0, ns + 30'(3 * n)} : sec + 32'(n);
            exp_n[i] += 8'(n);
        end
        @(posedge clk);
        phy.sfd(m, n);
        repeat (2) @(posedge clk);
        // status flags show the new captures
        rdc(PTC_STAT_OFS, {29'h0, m & en}, 1'b0);
        foreach (ofs[i]) rdc(ofs[i], exp_v[i], 1'b0);
        // Reading the capture words acknowledges every flag
        rdc(PTC_STAT_OFS, 32'h0, 1'b0);
        foreach (irq_n[i]) chk({24'h0, irq_n[i]}, {24'h0, exp_n[i]});
    endtask : t_cap

    task automatic t_en(input logic [2:0] m);
        apb(1'b1, PTC_CTRL_OFS, {29'h0, m});
        en = m;
        rdc(PTC_CTRL_OFS, {29'h0, m}, 1'b0);
        t_cap(3'h7, 2);
    endtask : t_en

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // Main sequence; nanoseconds start near wrap
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = 48'h0;
        {sec, ns, en} = {32'h1234_5670, 30'h3fff_fff0, 3'h7};
        foreach (irq_n[i]) {irq_n[i], exp_n[i], exp_v[i]} = 48'h0;
        {bad_count, cmp_count} = 64'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        for (int k = 0; k < 3; k++) t_cap(3'(1 << k), 1);
        t_cap(3'h6, 2);
        t_en(3'h2);
        t_en(3'h7);
        summarize();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule : tb_top
